// *** logic/crs_sw_host.sv ***
// Software agent: AXI4-Lite registers driving slot command sequences
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module crs_sw_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  crs_slot_if.sw           s
);
  import crs_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_INIT, S_POLL, S_SETID, S_REQ, S_CLR, S_CAPT, S_CHECK
  } crs_st_e;

  crs_st_e      st_q;
  logic [1:0]   wt_q;
  logic [3:0]   slot_q;
  logic         stop_q;
  logic [7:0]   aw_q;
  logic [31:0]  wd_q;
  logic [3:0]   ws_q;
  logic         awready_q;
  logic         wready_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         arready_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;
  logic [31:0]  txid_q;
  logic [31:0]  mask_q;
  logic [31:0]  fmt_q;
  logic [31:0]  inten_q;
  logic [15:0]  iclr_q;
  logic         go_q;
  crs_op_e      op_q;
  logic [3:0]   cslot_q;
  logic         wr_en_q;
  logic [7:0]   wr_data_q;
  logic         id_we_q;
  logic [7:0]   last_q;
  logic [28:0]  rxid_q;
  logic [3:0]   rxdlc_q;
  logic [15:0]  rxts_q;
  logic [63:0]  rxdat_q;
  logic [15:0]  retry_q;
  logic         do_wr;

  function automatic logic [31:0] crs_merge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : crs_merge

  // Address and data held apart; write done once both are in
  assign do_wr = ~awready_q & ~wready_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
      aw_q      <= 8'h00;
      wd_q      <= 32'h0;
      ws_q      <= 4'h0;
      txid_q    <= 32'h0;
      mask_q    <= 32'h0;
      fmt_q     <= 32'h0;
      inten_q   <= 32'h0;
      iclr_q    <= 16'h0;
      go_q      <= 1'b0;
      op_q      <= OP_NOP;
      cslot_q   <= 4'h0;
    end else begin
      iclr_q <= 16'h0;
      go_q   <= 1'b0;
      if (awvalid && awready_q) begin
        aw_q      <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wd_q     <= wdata;
        ws_q     <= wstrb;
        wready_q <= 1'b0;
      end
      if (bvalid_q && bready) bvalid_q <= 1'b0;
      if (do_wr) begin
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
        bvalid_q  <= 1'b1;
        bresp_q   <= RESP_OK;
        unique case (aw_q)
          A_CMD: begin
            // Commands while a sequence runs are dropped
            if (st_q == S_IDLE && ws_q[0]) begin
              cslot_q <= wd_q[3:0];
              op_q    <= crs_op_e'(wd_q[5:4]);
              go_q    <= 1'b1;
            end
          end
          A_TXID:  txid_q  <= crs_merge(txid_q, wd_q, ws_q);
          A_MASK:  mask_q  <= crs_merge(mask_q, wd_q, ws_q);
          A_FMT:   fmt_q   <= crs_merge(fmt_q, wd_q, ws_q);
          A_INTEN: inten_q <= crs_merge(inten_q, wd_q, ws_q);
          A_STAT:  iclr_q  <= wd_q[31:16] & {{8{ws_q[3]}}, {8{ws_q[2]}}};
          default: bresp_q <= RESP_ERR;
        endcase
      end
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OK;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OK;
      unique case (araddr)
        A_CMD:    rdata_q <= {26'h0, op_q, cslot_q};
        A_TXID:   rdata_q <= txid_q;
        A_MASK:   rdata_q <= mask_q;
        A_FMT:    rdata_q <= fmt_q;
        A_INTEN:  rdata_q <= inten_q;
        A_STAT:   rdata_q <= {s.int_stat, last_q, 7'h0, st_q != S_IDLE};
        A_RXID:   rdata_q <= {3'h0, rxid_q};
        A_RXINFO: rdata_q <= {rxts_q, 12'h0, rxdlc_q};
        A_RXLO:   rdata_q <= rxdat_q[31:0];
        A_RXHI:   rdata_q <= rxdat_q[63:32];
        A_RETRY:  rdata_q <= {16'h0, retry_q};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= RESP_ERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Command sequences; a wait covers the device readback delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= S_IDLE;
      wt_q      <= 2'h0;
      slot_q    <= 4'h0;
      stop_q    <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_data_q <= CTL_STOP;
      id_we_q   <= 1'b0;
      last_q    <= 8'h00;
      rxid_q    <= '0;
      rxdlc_q   <= 4'h0;
      rxts_q    <= 16'h0;
      rxdat_q   <= 64'h0;
      retry_q   <= 16'h0;
    end else begin
      wr_en_q <= 1'b0;
      id_we_q <= 1'b0;
      if (wt_q != 2'h0) begin
        wt_q <= wt_q - 2'h1;
      end else begin
        unique case (st_q)
          S_IDLE: begin
            if (go_q && op_q != OP_NOP) begin
              slot_q <= cslot_q;
              stop_q <= (op_q == OP_STOP);
              st_q   <= (op_q == OP_READ) ? S_CLR : S_INIT;
            end
          end
          S_INIT: begin
            wr_en_q   <= 1'b1;
            wr_data_q <= CTL_STOP;
            wt_q      <= RD_WAIT;
            st_q      <= S_POLL;
          end
          S_POLL: begin
            last_q <= s.rd_ctrl;
            if (!s.rd_ctrl[B_ACT]) begin
              st_q <= stop_q ? S_IDLE : S_SETID;
            end
          end
          S_SETID: begin
            id_we_q <= 1'b1;
            st_q    <= S_REQ;
          end
          S_REQ: begin
            wr_en_q   <= 1'b1;
            wr_data_q <= CTL_REM_REQ;
            st_q      <= S_IDLE;
          end
          S_CLR: begin
            wr_en_q   <= 1'b1;
            wr_data_q <= CTL_RX_KEEP;
            wt_q      <= RD_WAIT;
            st_q      <= S_CAPT;
          end
          S_CAPT: begin
            rxid_q  <= s.rd_id;
            rxdlc_q <= s.rd_dlc;
            rxts_q  <= s.rd_ts;
            rxdat_q <= s.rd_data;
            st_q    <= S_CHECK;
          end
          S_CHECK: begin
            last_q <= s.rd_ctrl;
            // New store during readout: start over
            if (s.rd_ctrl[B_DN]) begin
              retry_q <= retry_q + 16'h1;
              st_q    <= S_CLR;
            end else begin
              st_q <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign awready   = awready_q;
  assign wready    = wready_q;
  assign bvalid    = bvalid_q;
  assign bresp     = bresp_q;
  assign arready   = arready_q;
  assign rvalid    = rvalid_q;
  assign rdata     = rdata_q;
  assign rresp     = rresp_q;
  assign s.wr_en   = wr_en_q;
  assign s.wr_slot = slot_q;
  assign s.wr_data = wr_data_q;
  assign s.id_we   = id_we_q;
  assign s.id_data = txid_q[28:0];
  assign s.fmt     = fmt_q[15:0];
  assign s.id_mask = mask_q[28:0];
  assign s.int_en  = inten_q[15:0];
  assign s.int_clr = iclr_q;
  assign s.rd_slot = slot_q;

endmodule : crs_sw_host

// *** logic/crs_pkg.sv ***
// Constants and types shared by the remote frame slot controller ends
package crs_pkg;

  localparam int           NSLOT        = 16;
  localparam int           ID_W         = 29;
  localparam int           TS_W         = 16;
  localparam int           BASIC_SLOT   = 14;
  // Slot control commands
  localparam logic [7:0]   CTL_STOP     = 8'h00;
  localparam logic [7:0]   CTL_REM_REQ  = 8'hA0;
  localparam logic [7:0]   CTL_RX_KEEP  = 8'hAE;
  localparam logic [7:0]   CTL_ABORT    = 8'h0F;
  // Slot control bit positions
  localparam int           B_TR         = 7;
  localparam int           B_RR         = 6;
  localparam int           B_RM         = 5;
  localparam int           B_RA         = 3;
  localparam int           B_ML         = 2;
  localparam int           B_DN         = 1;
  localparam int           B_ACT        = 0;
  // Host register byte offsets
  localparam logic [7:0]   A_CMD        = 8'h00;
  localparam logic [7:0]   A_TXID       = 8'h04;
  localparam logic [7:0]   A_MASK       = 8'h08;
  localparam logic [7:0]   A_FMT        = 8'h0C;
  localparam logic [7:0]   A_INTEN      = 8'h10;
  localparam logic [7:0]   A_STAT       = 8'h14;
  localparam logic [7:0]   A_RXID       = 8'h18;
  localparam logic [7:0]   A_RXINFO     = 8'h1C;
  localparam logic [7:0]   A_RXLO       = 8'h20;
  localparam logic [7:0]   A_RXHI       = 8'h24;
  localparam logic [7:0]   A_RETRY      = 8'h28;
  localparam logic [1:0]   RESP_OK      = 2'h0;
  localparam logic [1:0]   RESP_ERR     = 2'h2;
  // Cycles from a control write to its readback
  localparam logic [1:0]   RD_WAIT      = 2'h2;

  typedef enum logic [1:0] {OP_NOP, OP_REMOTE, OP_READ, OP_STOP} crs_op_e;

  typedef struct packed {
    logic            tr;
    logic            rr;
    logic            rm;
    logic            ra;
    logic            ml;
    logic            dn;
    logic            act;
    logic            ab;
    logic [ID_W-1:0] id;
    logic [3:0]      dlc;
    logic [TS_W-1:0] ts;
    logic [63:0]     data;
  } crs_slot_s;

endpackage : crs_pkg

// *** logic/crs_slot_if.sv ***
// Slot register access between the controller and its software agent
`timescale 1ns/10ps
interface crs_slot_if;
  logic        wr_en;
  logic [3:0]  wr_slot;
  logic [7:0]  wr_data;
  logic        id_we;
  logic [28:0] id_data;
  logic [15:0] fmt;
  logic [28:0] id_mask;
  logic [15:0] int_en;
  logic [15:0] int_clr;
  logic [3:0]  rd_slot;
  logic [7:0]  rd_ctrl;
  logic [28:0] rd_id;
  logic [3:0]  rd_dlc;
  logic [15:0] rd_ts;
  logic [63:0] rd_data;
  logic [15:0] int_stat;

  modport dev (
    input  wr_en, wr_slot, wr_data, id_we, id_data, fmt, id_mask,
    input  int_en, int_clr, rd_slot,
    output rd_ctrl, rd_id, rd_dlc, rd_ts, rd_data, int_stat
  );
  modport sw (
    output wr_en, wr_slot, wr_data, id_we, id_data, fmt, id_mask,
    output int_en, int_clr, rd_slot,
    input  rd_ctrl, rd_id, rd_dlc, rd_ts, rd_data, int_stat
  );
endinterface : crs_slot_if

// *** logic/crs_slot_dev.sv ***
// Sixteen message slots for remote frame send and data frame receive
`timescale 1ns/10ps
module crs_slot_dev (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   basic_mode,
  input  wire logic                   intermission,
  input  wire logic                   tx_ok,
  input  wire logic                   tx_fail,
  input  wire logic                   rx_valid,
  input  wire logic [crs_pkg::ID_W-1:0] rx_id,
  input  wire logic                   rx_ext,
  input  wire logic                   rx_remote,
  input  wire logic [3:0]             rx_dlc,
  input  wire logic [63:0]            rx_data,
  output logic                        tx_start,
  output logic [3:0]                  tx_slot,
  output logic [crs_pkg::ID_W-1:0]    tx_id,
  output logic                        tx_ext,
  output logic                        irq,
  crs_slot_if.dev                     s
);
  import crs_pkg::*;

  crs_slot_s         sl_q [NSLOT];
  logic [NSLOT-1:0]  pend;
  logic [NSLOT-1:0]  match;
  logic [NSLOT-1:0]  ok_vec;
  logic [NSLOT-1:0]  hit_vec;
  logic [3:0]        tx_sel;
  logic              tx_any;
  logic              tx_go;
  logic [3:0]        rx_sel;
  logic              rx_any;
  logic              rx_store;
  logic              busy_q;
  logic [3:0]        cur_q;
  logic [TS_W-1:0]   tsc_q;
  logic [NSLOT-1:0]  int_q;
  logic              irq_q;
  logic              tx_start_q;
  logic [3:0]        tx_slot_q;
  logic [ID_W-1:0]   tx_id_q;
  logic              tx_ext_q;
  logic [7:0]        rd_ctrl_q;
  logic [ID_W-1:0]   rd_id_q;
  logic [3:0]        rd_dlc_q;
  logic [TS_W-1:0]   rd_ts_q;
  logic [63:0]       rd_data_q;

  // Lowest pending slot wins; scanning down keeps the last hit
  always_comb begin
    tx_sel = 4'h0;
    tx_any = 1'b0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        tx_sel = 4'(i);
        tx_any = 1'b1;
      end
    end
  end

  // First matching slot from slot 0 upward takes the frame
  always_comb begin
    rx_sel = 4'h0;
    rx_any = 1'b0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (match[i]) begin
        rx_sel = 4'(i);
        rx_any = 1'b1;
      end
    end
  end

  // Choice only at an intermission with the line free
  assign tx_go    = intermission & ~busy_q & tx_any;
  // No match means no slot sees a write at all
  assign rx_store = rx_valid & rx_any;

  // One independent slot per generate pass
  for (genvar g = 0; g < NSLOT; g++) begin : g_slot
    localparam logic [3:0] IDX = 4'(g);
    logic wsel;
    logic go;
    logic mine;
    logic hit;

    assign wsel = s.wr_en && (s.wr_slot == IDX);
    assign go   = tx_go && (tx_sel == IDX);
    assign mine = busy_q && (cur_q == IDX);
    assign hit  = rx_store && (rx_sel == IDX);
    assign ok_vec[g]  = mine & tx_ok;
    assign hit_vec[g] = hit;

    // Pending remote frame; top two slots barred in shared mode
    assign pend[g] = sl_q[g].tr & sl_q[g].ra & ~sl_q[g].act
                   & ~sl_q[g].ab
                   & ~(basic_mode && (g >= BASIC_SLOT));

    // Data frames only, masked identifier, same format
    assign match[g] = (sl_q[g].rr | (sl_q[g].tr & sl_q[g].rm))
                    & ~rx_remote
                    & (((rx_id ^ sl_q[g].id) & s.id_mask) == '0)
                    & (rx_ext == s.fmt[g]);

    // Assignments after the identifier write are hardware events, so they win over a control write in the same cycle
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sl_q[g] <= '0;
      end else begin
        if (wsel) begin
          if (s.wr_data == CTL_ABORT) begin
            sl_q[g].ab <= 1'b1;
          end else begin
            sl_q[g].tr <= s.wr_data[B_TR];
            sl_q[g].rr <= s.wr_data[B_RR];
            sl_q[g].rm <= s.wr_data[B_RM];
            // Only an exact request re-arms sending
            sl_q[g].ra <= (s.wr_data == CTL_REM_REQ)
                        | (sl_q[g].ra & s.wr_data[B_RA]);
            sl_q[g].ml <= sl_q[g].ml & s.wr_data[B_ML];
            // Every control write other than the abort code clears done; a store below still wins
            sl_q[g].dn <= 1'b0;
            sl_q[g].ab <= 1'b0;
          end
        end else if (sl_q[g].ab && !sl_q[g].act) begin
          // Abort taken while waiting or after a failed attempt
          sl_q[g].tr <= 1'b0;
          sl_q[g].ra <= 1'b0;
          sl_q[g].ab <= 1'b0;
        end
        if (s.id_we && (s.wr_slot == IDX)) begin
          sl_q[g].id <= s.id_data;
        end
        // Active while sending, and for the cycle of a store
        sl_q[g].act <= go | (mine & ~tx_ok & ~tx_fail) | hit;
        if (mine && tx_ok) begin
          sl_q[g].ts <= tsc_q;
          sl_q[g].ra <= 1'b0;
          sl_q[g].ab <= 1'b0;
        end
        if (hit) begin
          sl_q[g].dn   <= 1'b1;
          sl_q[g].ml   <= sl_q[g].ml | sl_q[g].dn;
          sl_q[g].ra   <= 1'b0;
          sl_q[g].id   <= rx_id;
          sl_q[g].dlc  <= rx_dlc;
          sl_q[g].data <= rx_data;
          sl_q[g].ts   <= tsc_q;
        end
      end
    end
  end

  // Free running stamp counter, one count per clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsc_q <= '0;
    end else begin
      tsc_q <= tsc_q + 1'b1;
    end
  end

  // Transmit engine: one frame on the line at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q     <= 1'b0;
      cur_q      <= 4'h0;
      tx_start_q <= 1'b0;
      tx_slot_q  <= 4'h0;
      tx_id_q    <= '0;
      tx_ext_q   <= 1'b0;
    end else begin
      tx_start_q <= tx_go;
      if (tx_go) begin
        busy_q    <= 1'b1;
        cur_q     <= tx_sel;
        tx_slot_q <= tx_sel;
        tx_id_q   <= sl_q[tx_sel].id;
        tx_ext_q  <= s.fmt[tx_sel];
      end else if (tx_ok || tx_fail) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Slot interrupt flags; the set term wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_q <= (int_q & ~s.int_clr) | ok_vec | hit_vec;
      irq_q <= |(int_q & s.int_en);
    end
  end

  // Registered readback; one cycle behind the slot select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ctrl_q <= 8'h00;
      rd_id_q   <= '0;
      rd_dlc_q  <= 4'h0;
      rd_ts_q   <= '0;
      rd_data_q <= '0;
    end else begin
      rd_ctrl_q <= {sl_q[s.rd_slot].tr, sl_q[s.rd_slot].rr,
                    sl_q[s.rd_slot].rm, 1'b0, sl_q[s.rd_slot].ra,
                    sl_q[s.rd_slot].ml, sl_q[s.rd_slot].dn,
                    sl_q[s.rd_slot].act};
      rd_id_q   <= sl_q[s.rd_slot].id;
      rd_dlc_q  <= sl_q[s.rd_slot].dlc;
      rd_ts_q   <= sl_q[s.rd_slot].ts;
      rd_data_q <= sl_q[s.rd_slot].data;
    end
  end

  // Outputs straight from flops
  assign tx_start   = tx_start_q;
  assign tx_slot    = tx_slot_q;
  assign tx_id      = tx_id_q;
  assign tx_ext     = tx_ext_q;
  assign irq        = irq_q;
  assign s.rd_ctrl  = rd_ctrl_q;
  assign s.rd_id    = rd_id_q;
  assign s.rd_dlc   = rd_dlc_q;
  assign s.rd_ts    = rd_ts_q;
  assign s.rd_data  = rd_data_q;
  assign s.int_stat = int_q;

endmodule : crs_slot_dev

// *** dv/crs_slot_monitor.sv ***
// Slot control readback and interrupt flag checks on the slot interface
`timescale 1ns/10ps
module crs_slot_monitor
  import crs_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        wr_en,
  input wire logic [3:0]  wr_slot,
  input wire logic [7:0]  wr_data,
  input wire logic [3:0]  rd_slot,
  input wire logic [7:0]  rd_ctrl,
  input wire logic [15:0] int_stat,
  input wire logic [15:0] int_clr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Frame landing in the slot that is being read back
  sequence store_s;
    $rose(rd_ctrl[B_DN]) && $stable(rd_slot);
  endsequence
  // Control write aimed at the slot on readback
  sequence cmd_s(logic [7:0] v);
    wr_en && wr_data == v && rd_slot == wr_slot;
  endsequence
  // Readback lags the write by up to three edges
  ra_set_a: assert property (cmd_s(CTL_REM_REQ) |-> ##[1:3]
    rd_ctrl[7:3] == 5'h15) else $error("remote request bits not set");
  stop_clr_a: assert property (cmd_s(CTL_STOP) |-> ##[1:3]
    rd_ctrl[7:1] == 7'h00) else $error("stop left slot bits set");
  keep_rx_a: assert property (cmd_s(CTL_RX_KEEP) |-> ##[1:3]
    rd_ctrl[7:4] == 4'hA && !rd_ctrl[B_DN]) else $error("AE write wrong");
  idle_req_a: assert property (cmd_s(CTL_REM_REQ) |->
    !rd_ctrl[B_ACT]) else $error("request while slot active");
  ml_over_a: assert property ($rose(rd_ctrl[B_ML]) && $stable(rd_slot)
    |-> $past(rd_ctrl[B_DN])) else $error("lost flag without overwrite");
  store_act_a: assert property (store_s |-> rd_ctrl[B_ACT]
    ##1 !rd_ctrl[B_ACT]) else $error("store activity not one cycle");
  store_int_a: assert property (store_s |-> int_stat[rd_slot])
    else $error("store without slot flag");
  flag_hold_a: assert property ((($past(int_stat) & ~int_stat)
    & ~$past(int_clr)) == 16'h0000) else $error("slot flag dropped");
endmodule : crs_slot_monitor

// *** dv/tb_top.sv ***
// Bench joining the software agent and the slot controller
`timescale 1ns/10ps
module tb_top;
  import crs_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, v;
  logic [3:0]  wstrb, rx_dlc, tx_slot;
  logic [1:0]  bresp, rresp;
  logic        basic_mode, intermission, tx_ok, tx_fail, rx_valid;
  logic        rx_ext, rx_remote, tx_start, tx_ext, irq;
  logic [28:0] rx_id, tx_id;
  logic [63:0] rx_data, d1, d2;
  logic [10:0] id;
  logic [34:0] e;
  logic [34:0] exp_q[$];
  logic [33:0] tx_q[$];
  int          errors, n_checks;
  crs_slot_if sif();
  crs_slot_dev crs_slot_dev_i(.aclk, .aresetn, .basic_mode, .intermission,
    .tx_ok, .tx_fail, .rx_valid, .rx_id, .rx_ext, .rx_remote, .rx_dlc,
    .rx_data, .tx_start, .tx_slot, .tx_id, .tx_ext, .irq, .s(sif));
  crs_sw_host crs_sw_host_i(.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .s(sif));
  crs_slot_monitor crs_slot_monitor_i(.aclk, .aresetn, .wr_en(sif.wr_en),
    .wr_slot(sif.wr_slot), .wr_data(sif.wr_data), .rd_slot(sif.rd_slot),
    .rd_ctrl(sif.rd_ctrl), .int_stat(sif.int_stat), .int_clr(sif.int_clr));
  // Free running clock, 8 ns period
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [33:0] s, input logic [33:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : check
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'h1; wdata <= d; wvalid <= 1'h1; bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask : wr
  // Note the expected answer, then read; c=0 marks a poll
  task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic c);
    exp_q.push_back({c, x});
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    v = rdata;
    rready <= 1'h0;
  endtask : rd
  task automatic cmd(input logic [1:0] op, input logic [3:0] sl);
    wr(A_CMD, {26'h0, op, sl});
    repeat (40) begin
      rd(A_STAT, 34'h0, 1'h0);
      if (v[0] === 1'h0) break;
    end
  endtask : cmd
  task automatic req(input logic [3:0] sl, input logic [10:0] i);
    wr(A_TXID, {21'h0, i});
    cmd(2'h1, sl);
  endtask : req
  task automatic im();
    @(posedge aclk) intermission <= 1'h1;
    @(posedge aclk) intermission <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : im
  task automatic fin(input logic ok);
    @(posedge aclk) begin tx_ok <= ok; tx_fail <= !ok; end
    @(posedge aclk) begin tx_ok <= 1'h0; tx_fail <= 1'h0; end
    repeat (3) @(posedge aclk);
  endtask : fin
  task automatic rx(input logic [10:0] i, input logic r, input logic [63:0] d);
    @(posedge aclk);
    rx_valid <= 1'h1; rx_id <= {18'h0, i}; rx_remote <= r; rx_data <= d;
    @(posedge aclk) rx_valid <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : rx
  // Oldest note is popped at each read answer and checked unless a poll; each frame start is checked against the oldest queued frame
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      if (e[34]) check({rresp, rdata}, e[33:0]);
    end
    if (tx_start === 1'h1) check({tx_ext, tx_id, tx_slot},
      (tx_q.size() > 0) ? tx_q.pop_front() : 34'h3FFFFFFFF);
  end
  // Watchdog, well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
  initial begin
    seed = 32'h4D; errors = 0; n_checks = 0; aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, basic_mode} = 6'h00;
    {intermission, tx_ok, tx_fail, rx_valid, rx_ext, rx_remote} = 6'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
    rx_id = 29'h0; rx_dlc = 4'h8; rx_data = 64'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    wr(A_MASK, 32'h1FFFFFFF);
    wr(A_INTEN, 32'h0000FFFF);
    wr(A_FMT, 32'h0);
    v = rnd(); id = v[10:0]; d1 = {rnd(), rnd()}; d2 = {rnd(), rnd()};
    req(4'h9, id ^ 11'h002); req(4'h5, id ^ 11'h001); req(4'h3, id);
    rx(id ^ 11'h002, 1'h0, d1);
    tx_q.push_back({19'h0, id, 4'h3}); im(); fin(1'h0);
    tx_q.push_back({19'h0, id, 4'h3}); im(); fin(1'h1);
    rd(A_STAT, {RESP_OK, 32'h02080000}, 1'h1);
    tx_q.push_back({19'h0, id ^ 11'h001, 4'h5}); im(); fin(1'h1);
    im();
    rx(id, 1'h0, d1); rx(id, 1'h0, d2);
    rx(id, 1'h1, d1); rx(id ^ 11'h004, 1'h0, d1);
    rd(A_STAT, {RESP_OK, 32'h02280000}, 1'h1);
    cmd(2'h2, 4'h3);
    rd(A_RXID, {RESP_OK, 21'h0, id}, 1'h1);
    rd(A_RXLO, {RESP_OK, d2[31:0]}, 1'h1);
    rd(A_RXHI, {RESP_OK, d2[63:32]}, 1'h1);
    rd(A_RETRY, {RESP_OK, 32'h0}, 1'h1);
    rd(A_STAT, {RESP_OK, 32'h0228A400}, 1'h1);
    basic_mode <= 1'h1; req(4'hE, id ^ 11'h008); im();
    basic_mode <= 1'h0;
    tx_q.push_back({19'h0, id ^ 11'h008, 4'hE}); im(); fin(1'h1);
    cmd(2'h3, 4'hE);
    rd(A_STAT, {RESP_OK, 32'h42280000}, 1'h1);
    check({33'h0, irq}, 34'h1);
    wr(A_STAT, 32'hFFFF0000);
    rd(A_STAT, {RESP_OK, 32'h0}, 1'h1);
    check({33'h0, irq}, 34'h0);
    rd(8'h3C, {RESP_ERR, 32'h0}, 1'h1);
    report_and_stop();
  end
endmodule : tb_top
